/* File: logic/arld_pkg.sv */
// Constants, register map and field layout for the 16-bit auto-reload timer.
// Contract
// - 16-bit registers written high byte, then low.
// - Low byte write moves held high byte in.
// - Held high byte reused until rewritten.
// - Run bit low: reset state, settings kept.
// - Run bit high again: resume same mode.
// - Run bit low: counter stopped at zero.
// - Counter decrements on clock divided 1/4/16.
// - Wrap without reload enable loads all ones.
// - Wrap with reload enable loads reload register.
// - Every wrap sets the wrap flag.
// - Selected event reloads counter when reload enabled.
// - Masked compare against zero and compare register.
// - Matches set zero and compare flags.
// - Mask highest bit n: period 2^(n+1).
// - Event captures counter into capture register.
// - Reload register captures only without reload enable.
// - No reload: two events capture, free running.
// - Reload: first event reloads, next captures.
// - Start source chosen by two select bits.
// - Matches and wraps drive pulse, overflow pins.
// - Overflow pin set/cleared-by-flag, or toggles.
// - Toggle pulse mode toggles on compare match.
// - Set/reset pulse mode: zero and compare levels.
// - Interrupt is OR of five enabled flags.
package arld_pkg;

    localparam int CNT_W = 16;

    // Byte addresses of the register map.
    localparam logic [3:0] ADR_CMP_H = 4'h0;
    localparam logic [3:0] ADR_CMP_L = 4'h1;
    localparam logic [3:0] ADR_RELOAD_CAPTURE_REG_H = 4'h2;
    localparam logic [3:0] ADR_RELOAD_CAPTURE_REG_L = 4'h3;
    localparam logic [3:0] ADR_MASK_H = 4'h4;
    localparam logic [3:0] ADR_MASK_L = 4'h5;
    localparam logic [3:0] ADR_CAP_H = 4'h6;
    localparam logic [3:0] ADR_CAP_L = 4'h7;
    localparam logic [3:0] ADR_CNT_H = 4'h8;
    localparam logic [3:0] ADR_CNT_L = 4'h9;
    localparam logic [3:0] ADR_CTRL = 4'ha;
    localparam logic [3:0] ADR_MODE = 4'hb;
    localparam logic [3:0] ADR_FLAG = 4'hc;
    localparam logic [3:0] ADR_IEN = 4'hd;

    // Control register fields.
    localparam int CTL_RUN = 0;
    localparam int CTL_PSC = 1;
    localparam int CTL_RLD = 3;
    localparam int CTL_SRC = 4;

    // Mode register fields.
    localparam int MOD_OVF_TGL = 0;
    localparam int MOD_OVF_EN = 1;
    localparam int MOD_PUL_POL = 2;
    localparam int MOD_PUL_EN = 3;
    localparam int MOD_PUL_TGL = 4;
    localparam int MOD_EV1_POL = 5;
    localparam int MOD_EV2_POL = 6;

    // Flag and interrupt enable bit positions.
    localparam int FLG_WRAP = 0;
    localparam int FLG_ZERO = 1;
    localparam int FLG_CMP = 2;
    localparam int FLG_EV1 = 3;
    localparam int FLG_EV2 = 4;
    localparam int FLG_N = 5;

    // Reset values and fixed counter and mask words.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [15:0] MASK_RST = 16'hffff;
    localparam logic [15:0] CNT_ONES = 16'hffff;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] MASK_MIN = 16'h0001;

    // Prescaler terminal counts for ratios 1, 4 and 16.
    localparam logic [3:0] PSC_T1 = 4'h0;
    localparam logic [3:0] PSC_T4 = 4'h3;
    localparam logic [3:0] PSC_T16 = 4'hf;

    // Start source select, {sel_b, sel_a}.
    typedef enum logic [1:0] {
        ARLD_SRC_RUN = 2'b00,
        ARLD_SRC_EV1 = 2'b01,
        ARLD_SRC_EV2 = 2'b10,
        ARLD_SRC_NONE = 2'b11
    } arld_src_t;

    // Terminal prescaler count for a ratio select code.
    function automatic logic [3:0] arld_psc_term(input logic [1:0] sel);
        case (sel)
            2'b00: arld_psc_term = PSC_T1;
            2'b01: arld_psc_term = PSC_T4;
            default: arld_psc_term = PSC_T16;
        endcase
    endfunction : arld_psc_term

    // Masked equality used by both comparators.
    function automatic logic arld_meq(input logic [15:0] a, input logic [15:0] b,
                                      input logic [15:0] m);
        arld_meq = ((a & m) == (b & m));
    endfunction : arld_meq

endpackage : arld_pkg

/* File: logic/arld_timer.sv */
// Auto-reload down counter with capture, masked compare and pin outputs.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module arld_timer
    import arld_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic event_input_one,
    input wire logic event_input_two,
    output logic overflow_pin,
    output logic pulse_pin,
    output logic timer_irq
);

    // The register pairs are built from two bytes, so only this width is served.
    if (CNT_WIDTH != 16) begin : g_bad_width
        $error("arld_timer supports only a 16-bit counter");
    end

    logic [7:0] hold_r;
    logic [15:0] cmp_r;
    logic [15:0] reload_capture_reg_r;
    logic [15:0] mask_r;
    logic [15:0] cp_r;
    logic [15:0] ct_r;
    logic [7:0] ctrl_r;
    logic [7:0] mode_r;
    logic [7:0] ien_r;
    logic [FLG_N-1:0] flag_r;
    logic [3:0] psc_r;
    logic run_d_r;
    logic upd_r;
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] filt_r;
    logic [1:0] filt_d_r;
    logic wait_r;
    logic [7:0] rdata_r;
    logic ovf_r;
    logic pwm_r;
    logic irq_r;

    // Bus handshake: one wait cycle, then the access is taken.
    wire req = avs_read | avs_write;
    wire wait_nxt = ~(req & wait_r);
    wire wr = avs_write & ~wait_r;
    wire rd_load = avs_read & wait_r;

    // Write strobes per address.
    wire we_cmp_h = wr & (avs_address == ADR_CMP_H);
    wire we_cmp_l = wr & (avs_address == ADR_CMP_L);
    wire we_rl_h = wr & (avs_address == ADR_RELOAD_CAPTURE_REG_H);
    wire we_rl_l = wr & (avs_address == ADR_RELOAD_CAPTURE_REG_L);
    wire we_msk_h = wr & (avs_address == ADR_MASK_H);
    wire we_msk_l = wr & (avs_address == ADR_MASK_L);
    wire we_ctrl = wr & (avs_address == ADR_CTRL);
    wire we_mode = wr & (avs_address == ADR_MODE);
    wire we_flag = wr & (avs_address == ADR_FLAG);
    wire we_ien = wr & (avs_address == ADR_IEN);

    // A high-byte write only fills the holding register.
    wire we_high = we_cmp_h | we_rl_h | we_msk_h;
    // The low byte joins the held byte into the full word.
    wire [15:0] word = {hold_r, avs_writedata};

    // Control decode.
    wire run = ctrl_r[CTL_RUN];
    wire run_rise = run & ~run_d_r;
    wire rld_en = ctrl_r[CTL_RLD];
    wire [1:0] psc_sel = ctrl_r[CTL_PSC+1:CTL_PSC];
    wire [1:0] src = ctrl_r[CTL_SRC+1:CTL_SRC];
    wire [1:0] ev_pol = {mode_r[MOD_EV2_POL], mode_r[MOD_EV1_POL]};

    // Filtered edges of the event inputs, active edge chosen by polarity bits.
    wire [1:0] ev_chg = filt_r ^ filt_d_r;
    wire [1:0] ev = ev_chg & ~(filt_r ^ ev_pol) & {2{run}};

    // Reload from the selected start source while reload is enabled.
    wire src_hit = ((src == ARLD_SRC_EV1) & ev[0]) | ((src == ARLD_SRC_EV2) & ev[1]) |
                   ((src == ARLD_SRC_RUN) & run_rise);
    wire reload_ev = rld_en & run & src_hit;

    // Prescaled tick at ratio 1, 4 or 16.
    wire tick = run & (psc_r == arld_psc_term(psc_sel));
    wire wrap = tick & (ct_r == CNT_ZERO);
    // Wrap value is all ones or the programmed reload value.
    wire [15:0] wrap_val = rld_en ? reload_capture_reg_r : CNT_ONES;

    // Counter next value; stopped and held at zero while not running.
    wire [15:0] ct_nxt = !run ? CNT_ZERO :
                         reload_ev ? reload_capture_reg_r :
                         wrap ? wrap_val :
                         tick ? ct_r - 16'h0001 : ct_r;
    wire [3:0] psc_nxt = (!run | tick | reload_ev) ? 4'h0 : psc_r + 4'h1;

    // A zero mask behaves like the lowest bit, a match every two ticks.
    wire [15:0] eff_mask = (mask_r == CNT_ZERO) ? MASK_MIN : mask_r;
    // Masked comparisons, evaluated once on each new counter value.
    wire zero_m = upd_r & arld_meq(ct_r, CNT_ZERO, eff_mask);
    wire cmp_m = upd_r & arld_meq(ct_r, cmp_r, eff_mask);

    // Captures; a pending flag blocks a further capture into the same register.
    wire cap_cp = ev[1] & ~flag_r[FLG_EV2];
    wire cap_rl = ev[0] & ~rld_en & ~flag_r[FLG_EV1];

    // Flags: hardware set wins over a software clear in the same cycle.
    wire [FLG_N-1:0] flag_set = {ev[1], ev[0], cmp_m, zero_m, wrap};
    wire [FLG_N-1:0] flag_clr = we_flag ? avs_writedata[FLG_N-1:0] : '0;
    wire [FLG_N-1:0] flag_nxt = (flag_r & ~flag_clr) | flag_set;

    // Overflow pin: toggles per wrap, or set on wrap until the flag clears.
    wire ovf_sr = wrap | (ovf_r & flag_nxt[FLG_WRAP]);
    wire ovf_nxt = !mode_r[MOD_OVF_EN] ? 1'b0 :
                   mode_r[MOD_OVF_TGL] ? ovf_r ^ wrap : ovf_sr;

    // Pulse pin: zero match gives the polarity level, compare match the other.
    wire pol = mode_r[MOD_PUL_POL];
    wire pwm_sr = zero_m ? pol : (cmp_m ? ~pol : pwm_r);
    // Toggle mode changes state on each compare match.
    wire pwm_nxt = !mode_r[MOD_PUL_EN] ? pol :
                   mode_r[MOD_PUL_TGL] ? pwm_r ^ cmp_m : pwm_sr;

    // Interrupt request from enabled flags.
    wire irq_nxt = |(flag_nxt & ien_r[FLG_N-1:0]);

    // Read data selection.
    logic [7:0] rd_mux;
    always_comb begin
        if (avs_address == ADR_CMP_H) begin
            rd_mux = cmp_r[15:8];
        end else if (avs_address == ADR_CMP_L) begin
            rd_mux = cmp_r[7:0];
        end else if (avs_address == ADR_RELOAD_CAPTURE_REG_H) begin
            rd_mux = reload_capture_reg_r[15:8];
        end else if (avs_address == ADR_RELOAD_CAPTURE_REG_L) begin
            rd_mux = reload_capture_reg_r[7:0];
        end else if (avs_address == ADR_MASK_H) begin
            rd_mux = mask_r[15:8];
        end else if (avs_address == ADR_MASK_L) begin
            rd_mux = mask_r[7:0];
        end else if (avs_address == ADR_CAP_H) begin
            rd_mux = cp_r[15:8];
        end else if (avs_address == ADR_CAP_L) begin
            rd_mux = cp_r[7:0];
        end else if (avs_address == ADR_CNT_H) begin
            rd_mux = ct_r[15:8];
        end else if (avs_address == ADR_CNT_L) begin
            rd_mux = ct_r[7:0];
        end else if (avs_address == ADR_CTRL) begin
            rd_mux = ctrl_r;
        end else if (avs_address == ADR_MODE) begin
            rd_mux = mode_r;
        end else if (avs_address == ADR_FLAG) begin
            rd_mux = {3'h0, flag_r};
        end else if (avs_address == ADR_IEN) begin
            rd_mux = ien_r;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Bus slave state and read data register.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            wait_r <= wait_nxt;
            if (rd_load) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Holding register for the upper byte.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_r <= 8'h00;
        end else if (we_high) begin
            hold_r <= avs_writedata;
        end
    end

    // Compare and mask words, loaded on their low-byte writes.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_r <= CNT_ZERO;
            mask_r <= MASK_RST;
        end else begin
            if (we_cmp_l) begin
                cmp_r <= word;
            end
            if (we_msk_l) begin
                mask_r <= word;
            end
        end
    end

    // Reload/capture word: a capture takes priority over a software write.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reload_capture_reg_r <= CNT_ZERO;
        end else if (cap_rl) begin
            reload_capture_reg_r <= ct_r;
        end else if (we_rl_l) begin
            reload_capture_reg_r <= word;
        end
    end

    // Capture word, taken before any reload in the same cycle.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cp_r <= CNT_ZERO;
        end else if (cap_cp) begin
            cp_r <= ct_r;
        end
    end

    // Control registers survive a cleared run bit, so a restart resumes.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            mode_r <= MODE_RST;
            ien_r <= IEN_RST;
        end else begin
            if (we_ctrl) begin
                ctrl_r <= avs_writedata;
            end
            if (we_mode) begin
                mode_r <= avs_writedata;
            end
            if (we_ien) begin
                ien_r <= avs_writedata;
            end
        end
    end

    // Counter and prescaler; both clear while stopped for low power.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ct_r <= CNT_ZERO;
            psc_r <= 4'h0;
            run_d_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            ct_r <= ct_nxt;
            psc_r <= psc_nxt;
            run_d_r <= run;
            upd_r <= run & (tick | reload_ev);
        end
    end

    // Event input synchronisers; a change counts once stages two and three agree.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= 2'b00;
            s2_r <= 2'b00;
            s3_r <= 2'b00;
            filt_r <= 2'b00;
            filt_d_r <= 2'b00;
        end else begin
            s1_r <= {event_input_two, event_input_one};
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
            filt_d_r <= filt_r;
        end
    end

    // Flags, pins and interrupt output.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= '0;
            ovf_r <= 1'b0;
            pwm_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            ovf_r <= ovf_nxt;
            pwm_r <= pwm_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign overflow_pin = ovf_r;
    assign pulse_pin = pwm_r;
    assign timer_irq = irq_r;

endmodule : arld_timer

/* File: tb/arld_event_src.sv */
// Event source model driving the timer's two event pins.
`timescale 1ns/1ps
module arld_event_src (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] fire,
    output logic event_input_one,
    output logic event_input_two
);
    logic [3:0] left_r [2];
    // Each request raises its pin for eight clocks, longer than the input filter.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            left_r[0] <= 4'h0;
            left_r[1] <= 4'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (fire[i]) begin
                    left_r[i] <= 4'h8;
                end else if (left_r[i] != 4'h0) begin
                    left_r[i] <= left_r[i] - 4'h1;
                end
            end
        end
    end
    // Pins are low whenever no pulse is in progress.
    assign event_input_one = (left_r[0] != 4'h0);
    assign event_input_two = (left_r[1] != 4'h0);
endmodule : arld_event_src

/* File: tb/arld_timer_properties.sv */
// Concurrent checks on the timer's bus answers, pins and interrupt.
`timescale 1ns/1ps
module arld_timer_checker
    import arld_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic event_input_one,
    input wire logic event_input_two,
    input wire logic overflow_pin,
    input wire logic pulse_pin,
    input wire logic timer_irq
);
    logic acc_w, acc_r, wclr, run_s;
    logic [7:0] hold_s, mode_s, ien_s;
    logic [15:0] cmp_s;
    logic [2:0] idle_s;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Accepted transfers are those seen with waitrequest low.
    assign acc_w = avs_write && !avs_waitrequest;
    assign acc_r = avs_read && !avs_waitrequest;
    assign wclr = acc_w && (avs_address == ADR_FLAG) && avs_writedata[FLG_WRAP];
    // Shadow copies of written state; idle_s counts stopped cycles up to seven.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hold_s <= 8'h00;
            cmp_s <= 16'h0000;
            run_s <= 1'b0;
            mode_s <= 8'h00;
            ien_s <= 8'h00;
            idle_s <= 3'h0;
        end else begin
            idle_s <= run_s ? 3'h0 : (idle_s == 3'h7) ? idle_s : idle_s + 3'h1;
            if (acc_w) begin
                case (avs_address)
                    ADR_CMP_H, ADR_RELOAD_CAPTURE_REG_H, ADR_MASK_H: hold_s <= avs_writedata;
                    ADR_CMP_L: cmp_s <= {hold_s, avs_writedata};
                    ADR_CTRL: run_s <= avs_writedata[CTL_RUN];
                    ADR_MODE: mode_s <= avs_writedata;
                    ADR_IEN: ien_s <= avs_writedata;
                    default: ;
                endcase
            end
        end
    end
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    cmp_low_a: assert property (acc_r && avs_address == ADR_CMP_L
        |-> avs_readdata == cmp_s[7:0]) else $error("compare low byte wrong");
    cmp_high_a: assert property (acc_r && avs_address == ADR_CMP_H
        |-> avs_readdata == cmp_s[15:8]) else $error("compare high byte wrong");
    stopped_zero_a: assert property (acc_r && avs_address[3:1] == 3'h4 && idle_s == 3'h7
        |-> avs_readdata == 8'h00) else $error("stopped counter not zero");
    irq_masked_a: assert property (ien_s == 8'h00 && $past(ien_s) == 8'h00
        |-> !timer_irq) else $error("interrupt without enable");
    ovf_off_a: assert property (!mode_s[MOD_OVF_EN] && $stable(mode_s)
        |-> !overflow_pin) else $error("overflow pin driven while off");
    pulse_idle_a: assert property (!mode_s[MOD_PUL_EN] && $stable(mode_s)
        |-> pulse_pin == mode_s[MOD_PUL_POL]) else $error("pulse pin idle level wrong");
    ovf_clear_a: assert property ($fell(overflow_pin) && mode_s[1:0] == 2'b10
        && $stable(mode_s) |-> $past(wclr)) else $error("overflow pin fell without clear");
endmodule : arld_timer_checker

bind arld_timer arld_timer_checker chk_i (.sys_clk(sys_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_input_one(event_input_one),
    .event_input_two(event_input_two), .overflow_pin(overflow_pin),
    .pulse_pin(pulse_pin), .timer_irq(timer_irq));

/* File: tb/arld_timer_tb.sv */
// Self-checking bench for the auto-reload timer.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module arld_timer_tb;
    import arld_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [7:0] avs_writedata = 8'h00;
    logic [7:0] avs_readdata;
    logic avs_waitrequest, event_input_one, event_input_two, overflow_pin, pulse_pin, timer_irq;
    logic [1:0] fire = 2'b00;
    logic [15:0] q[$];
    logic [15:0] note;
    logic [31:0] seed = 32'h2737;
    int failures = 0;
    int checks = 0;
    int tg;
    arld_timer uut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_input_one(event_input_one), .event_input_two(event_input_two),
        .overflow_pin(overflow_pin), .pulse_pin(pulse_pin), .timer_irq(timer_irq));
    arld_event_src src_i (.sys_clk(sys_clk), .rstn(rstn), .fire(fire),
        .event_input_one(event_input_one), .event_input_two(event_input_two));
    // Clock at 10 MHz.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // One bus transfer, held until waitrequest is seen low.
    task automatic bus(input logic [3:0] a, input logic r, input logic [7:0] d);
        avs_address <= a;
        avs_read <= r;
        avs_write <= !r;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b0, d);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        q.push_back({m, e});
        bus(a, 1'b1, 8'h00);
    endtask : rd
    // Counts level changes of one output pin over n clocks.
    task automatic toggles(input logic pick, input int n);
        logic last;
        last = pick ? pulse_pin : overflow_pin;
        tg = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if ((pick ? pulse_pin : overflow_pin) !== last) tg++;
            last = pick ? pulse_pin : overflow_pin;
        end
    endtask : toggles
    task automatic pulse_events(input logic [1:0] which);
        fire <= which;
        @(posedge sys_clk);
        fire <= 2'b00;
        repeat (12) @(posedge sys_clk);
    endtask : pulse_events
    task automatic tally_and_finish;
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    // Takes the oldest note whenever read data is accepted.
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            note = q.pop_front();
            `CHK("readdata", note[7:0], avs_readdata & note[15:8])
        end
    end
    // Cuts a hang short.
    initial begin
        #(20000 * 100);
        failures++;
        tally_and_finish();
    end
    // Main sequence.
    initial begin
        rstn = 1'b0;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(ADR_MASK_H, 8'hff, 8'hff);
        rd(ADR_CNT_L, 8'hff, 8'h00);
        rd(4'he, 8'hff, 8'h00);
        repeat (32) seed = lfsr(seed);
        wr(ADR_CMP_H, seed[15:8]);
        wr(ADR_CMP_L, seed[7:0]);
        rd(ADR_CMP_L, 8'hff, seed[7:0]);
        wr(ADR_CMP_L, seed[23:16]);
        rd(ADR_CMP_H, 8'hff, seed[15:8]);
        wr(ADR_RELOAD_CAPTURE_REG_H, 8'h00);
        wr(ADR_RELOAD_CAPTURE_REG_L, 8'h03);
        wr(ADR_CTRL, 8'h09); // Run, ratio one, reload, start on run bit.
        wr(ADR_MODE, 8'h03);
        toggles(1'b0, 40);
        `CHK("overflow toggles", 10, tg)
        rd(ADR_CNT_H, 8'hff, 8'h00);
        rd(ADR_CNT_L, 8'hfc, 8'h00);
        wr(ADR_CTRL, 8'h0b); // Same reload setup at ratio four, period sixteen clocks.
        repeat (16) @(posedge sys_clk);
        toggles(1'b0, 64);
        `CHK("ratio four toggles", 4, tg)
        wr(ADR_CTRL, 8'h09);
        wr(ADR_IEN, 8'h01);
        repeat (6) @(posedge sys_clk);
        `CHK("irq", 1'b1, timer_irq)
        wr(ADR_MODE, 8'h02);
        wr(ADR_FLAG, 8'h01);
        wr(ADR_IEN, 8'h00);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b0, timer_irq)
        wr(ADR_CMP_H, 8'h00);
        wr(ADR_CMP_L, 8'h02);
        wr(ADR_MODE, 8'h18);
        toggles(1'b1, 40);
        `CHK("pulse toggles", 10, tg)
        wr(ADR_MODE, 8'h04);
        repeat (2) @(posedge sys_clk);
        `CHK("pulse idle", 1'b1, pulse_pin)
        wr(ADR_CTRL, 8'h00);
        repeat (8) @(posedge sys_clk);
        rd(ADR_CNT_H, 8'hff, 8'h00);
        rd(ADR_RELOAD_CAPTURE_REG_L, 8'hff, 8'h03);
        wr(ADR_CMP_L, 8'h00);
        wr(ADR_MODE, 8'h18);
        for (int i = 0; i < 4; i++) begin
            wr(ADR_CTRL, 8'h00);
            wr(ADR_MASK_H, 8'h00);
            wr(ADR_MASK_L, 8'((1 << i) - 1));
            wr(ADR_CTRL, 8'h01);
            repeat (16) @(posedge sys_clk); // Let the match pattern settle first.
            toggles(1'b1, 40);
            `CHK("mask toggles", (i == 0) ? 20 : (40 >> i), tg)
        end
        wr(ADR_CTRL, 8'h00);
        wr(ADR_FLAG, 8'h1f);
        wr(ADR_MODE, 8'h60);
        wr(ADR_CTRL, 8'h05); // Run, ratio sixteen, free running.
        repeat (20) @(posedge sys_clk);
        pulse_events(2'b11);
        rd(ADR_CAP_H, 8'hff, 8'hff);
        rd(ADR_RELOAD_CAPTURE_REG_H, 8'hff, 8'hff);
        rd(ADR_FLAG, 8'h18, 8'h18);
        wr(ADR_CTRL, 8'h00);
        wr(ADR_RELOAD_CAPTURE_REG_H, 8'h12);
        wr(ADR_RELOAD_CAPTURE_REG_L, 8'h34);
        wr(ADR_FLAG, 8'h1f);
        wr(ADR_CTRL, 8'h1d); // Run, ratio sixteen, reload, start on event one.
        repeat (200) @(posedge sys_clk); // Counter drifts well below the reload value.
        pulse_events(2'b01);
        rd(ADR_RELOAD_CAPTURE_REG_L, 8'hff, 8'h34);
        rd(ADR_CNT_H, 8'hff, 8'h12);
        rd(ADR_CNT_L, 8'hf0, 8'h30);
        pulse_events(2'b10);
        rd(ADR_CAP_H, 8'hff, 8'h12);
        tally_and_finish();
    end
endmodule : arld_timer_tb
